// File: rtl/wsc_regs.svh
// Register offsets, field positions, reset values and timing counts of the sideband block
`ifndef WSC_REGS_SVH
`define WSC_REGS_SVH
// Register word addresses
`define WSC_ADDR_CTRL 4'h0
`define WSC_ADDR_BACKOFF 4'h1
`define WSC_ADDR_ANT_SEL 4'h2
`define WSC_ADDR_TBL_IDX 4'h3
`define WSC_ADDR_TBL_DATA 4'h4
`define WSC_ADDR_MIPI_CMD 4'h5
`define WSC_ADDR_INT_STAT 4'h6
`define WSC_ADDR_INT_MASK 4'h7
`define WSC_ADDR_STATUS 4'h8
`define WSC_ADDR_STRAPS 4'h9
// Control fields
`define WSC_CTRL_WAKE 0
`define WSC_CTRL_MIPI_MODE 1
`define WSC_CTRL_RESET 8'h00
// Interrupt status bits
`define WSC_INT_BACKOFF_ON 0
`define WSC_INT_BACKOFF_OFF 1
`define WSC_INT_WAKE_DONE 2
`define WSC_INT_MIPI_DONE 3
// Status fields
`define WSC_ST_BACKOFF 0
`define WSC_ST_WAKE_BUSY 1
`define WSC_ST_MIPI_BUSY 2
// Reset values
`define WSC_BACKOFF_RESET 8'h00
`define WSC_STRAPS_VALUE 4'h0
// Timing: wake pulse one second at 250 MHz
`define WSC_WAKE_PULSE_S 1
`define WSC_CLK_HZ 250000000
`define WSC_WAKE_CYCLES (`WSC_WAKE_PULSE_S * `WSC_CLK_HZ)
`define WSC_MIPI_DIV 8
`endif

// File: rtl/wsc_pkg.sv
// Types shared by the sideband control modules
`default_nettype none
package wsc_pkg;
  typedef logic [7:0] wsc_byte_t;
  typedef logic [3:0] wsc_ant_t;
  typedef enum logic [1:0] {WSC_MIPI_IDLE, WSC_MIPI_SHIFT, WSC_MIPI_DONE} wsc_mipi_state_t;
endpackage
`default_nettype wire

// File: rtl/wsc_mipi_if.sv
// Interface between the sideband top and its serial tuner writer
`timescale 1ns/1ns
`default_nettype none
interface wsc_mipi_if;
  logic start;
  logic [15:0] word;
  logic busy;
  logic done;
  modport ctl (output start, output word, input busy, input done);
  modport ser (input start, input word, output busy, output done);
endinterface
`default_nettype wire

// File: rtl/wsc_mipi_ser.sv
// Two-wire serial writer that shifts one 16-bit tuner word out MSB first
`timescale 1ns/1ns
`default_nettype none
`include "wsc_regs.svh"
module wsc_mipi_ser #(
  parameter int DIV = `WSC_MIPI_DIV
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Command side
  wsc_mipi_if.ser cmd,
  // Serial pins
  output logic mipi_clk,
  output logic mipi_data
);
  import wsc_pkg::*;

  // Divider counter is eight bits and a bit needs two phases
  if (DIV < 2 || DIV > 255) begin
    $error("wsc_mipi_ser: DIV out of range");
  end

  // ==========================================
  // Bit-rate enable
  logic [7:0] div_q;
  logic tick;
  assign tick = (div_q == 8'(DIV - 1));
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      div_q <= 8'h00;
    end else if (tick) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  // ==========================================
  // Shift engine: data changes with clock low, sampled on rising clock
  wsc_mipi_state_t state_q;
  logic [15:0] sh_q;
  logic [4:0] cnt_q;
  logic phase_q;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= WSC_MIPI_IDLE;
      sh_q <= 16'h0000;
      cnt_q <= 5'h00;
      phase_q <= 1'b0;
      mipi_clk <= 1'b0;
      mipi_data <= 1'b0;
    end else begin
      case (state_q)
        WSC_MIPI_IDLE: begin
          mipi_clk <= 1'b0;
          if (cmd.start) begin
            sh_q <= cmd.word;
            cnt_q <= 5'h00;
            phase_q <= 1'b0;
            state_q <= WSC_MIPI_SHIFT;
          end
        end
        WSC_MIPI_SHIFT: begin
          if (tick) begin
            phase_q <= ~phase_q;
            if (!phase_q) begin
              mipi_clk <= 1'b0;
              mipi_data <= sh_q[15];
            end else begin
              mipi_clk <= 1'b1;
              sh_q <= {sh_q[14:0], 1'b0};
              cnt_q <= cnt_q + 5'h01;
              if (cnt_q == 5'h0F) begin
                state_q <= WSC_MIPI_DONE;
              end
            end
          end
        end
        WSC_MIPI_DONE: begin
          if (tick) begin
            mipi_clk <= 1'b0;
            mipi_data <= 1'b0;
            state_q <= WSC_MIPI_IDLE;
          end
        end
        default: state_q <= WSC_MIPI_IDLE;
      endcase
    end
  end

  assign cmd.busy = (state_q != WSC_MIPI_IDLE);
  assign cmd.done = (state_q == WSC_MIPI_DONE) && tick;
endmodule
`default_nettype wire

// File: rtl/wsc_top.sv
// Sideband control of a cellular modem card: wake, back-off, antenna, coexistence, straps
//
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "wsc_regs.svh"
module wsc_top #(
  parameter int TBL_DEPTH = 16,
  parameter int WAKE_CYCLES = `WSC_WAKE_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq,
  // Host wake, open drain
  input wire logic host_wake_request_n_i,
  output logic host_wake_request_n_o,
  output logic host_wake_request_n_oe_n,
  // Transmit power back-off from host
  input wire logic tx_power_backoff_n,
  // Radio core status in, back-off controls out
  input wire logic cell_tx_active,
  input wire logic cell_frame_sync,
  output logic absorption_rate_limit,
  output wsc_pkg::wsc_byte_t backoff_amount,
  // Antenna control
  output logic antenna_switch_ctl_0,
  output logic antenna_switch_ctl_1,
  output logic antenna_switch_ctl_2,
  output logic antenna_switch_ctl_3,
  output logic mipi_clk,
  output logic mipi_data,
  // Coexistence
  output logic coexist_line_1,
  output logic coexist_line_2,
  output logic coexist_line_3,
  // Configuration straps
  output logic [3:0] config_strap
);
  import wsc_pkg::*;

  localparam int IW = (TBL_DEPTH > 1) ? $clog2(TBL_DEPTH) : 1;

  // Index bits must cover every entry and no more, so depth is a power of two
  if (TBL_DEPTH < 2 || TBL_DEPTH > 16 || (TBL_DEPTH & (TBL_DEPTH - 1)) != 0) begin
    $error("wsc_top: TBL_DEPTH must be a power of two, 2..16");
  end
  if (WAKE_CYCLES < 2) begin
    $error("wsc_top: WAKE_CYCLES must be at least 2");
  end

  // ==========================================
  // Input synchronisers
  logic bo_s1_q, bo_s2_q;
  logic tx_s1_q, tx_s2_q;
  logic fs_s1_q, fs_s2_q;
  // Pin level unknown at reset; assume released so back-off starts off
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      bo_s1_q <= 1'b1;
      bo_s2_q <= 1'b1;
    end else begin
      bo_s1_q <= tx_power_backoff_n;
      bo_s2_q <= bo_s1_q;
    end
  end
  // Core status may come from another clock, so resync as well
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tx_s1_q <= 1'b0;
      tx_s2_q <= 1'b0;
      fs_s1_q <= 1'b0;
      fs_s2_q <= 1'b0;
    end else begin
      tx_s1_q <= cell_tx_active;
      tx_s2_q <= tx_s1_q;
      fs_s1_q <= cell_frame_sync;
      fs_s2_q <= fs_s1_q;
    end
  end

  // ==========================================
  // Back-off level and edge events
  logic bo_prev_q;
  logic bo_on_ev, bo_off_ev;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      bo_prev_q <= 1'b1;
    end else begin
      bo_prev_q <= bo_s2_q;
    end
  end
  // Host filters bounce, so no glitch filter here
  assign bo_on_ev = bo_prev_q && !bo_s2_q;
  assign bo_off_ev = !bo_prev_q && bo_s2_q;

  // ==========================================
  // Register file
  wsc_byte_t ctrl_q;
  wsc_byte_t backoff_q;
  wsc_ant_t ant_sel_q;
  logic [IW-1:0] tbl_idx_q;
  logic [15:0] mipi_word_q;
  logic mipi_go_q;
  logic [3:0] int_stat_q, int_mask_q;
  logic [3:0] tbl_q [TBL_DEPTH];
  logic wake_busy;
  wsc_mipi_if mif();

  logic wake_go;
  assign wake_go = reg_wr && (reg_addr == `WSC_ADDR_CTRL) && reg_wdata[`WSC_CTRL_WAKE];

  // Control, amount, selection and serial command registers
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= `WSC_CTRL_RESET;
      backoff_q <= `WSC_BACKOFF_RESET;
      ant_sel_q <= 4'h0;
      tbl_idx_q <= '0;
      mipi_word_q <= 16'h0000;
      mipi_go_q <= 1'b0;
    end else begin
      mipi_go_q <= 1'b0;
      if (reg_wr) begin
        if (reg_addr == `WSC_ADDR_CTRL) begin
          ctrl_q <= {reg_wdata[7:1], 1'b0}; // wake bit is a strobe
        end else if (reg_addr == `WSC_ADDR_BACKOFF) begin
          backoff_q <= reg_wdata[7:0];
        end else if (reg_addr == `WSC_ADDR_ANT_SEL) begin
          ant_sel_q <= reg_wdata[3:0];
        end else if (reg_addr == `WSC_ADDR_TBL_IDX) begin
          tbl_idx_q <= reg_wdata[IW-1:0];
        end else if (reg_addr == `WSC_ADDR_MIPI_CMD) begin
          // Command dropped while busy; software polls status first
          if (!mif.busy) begin
            mipi_word_q <= reg_wdata[15:0];
            mipi_go_q <= 1'b1;
          end
        end
      end
    end
  end

  // Tuner table: one entry written per data access
  generate
    for (genvar i = 0; i < TBL_DEPTH; i++) begin : g_tbl
      always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          tbl_q[i] <= 4'h0;
        end else if (reg_wr && reg_addr == `WSC_ADDR_TBL_DATA && tbl_idx_q == IW'(i)) begin
          tbl_q[i] <= reg_wdata[3:0];
        end
      end
    end
  endgenerate

  // Sticky interrupts, write one to clear; a new event beats the clear
  logic [3:0] ev;
  logic wake_done_ev;
  assign ev = {mif.done, wake_done_ev, bo_off_ev, bo_on_ev};
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      int_stat_q <= 4'h0;
      int_mask_q <= 4'h0;
    end else begin
      if (reg_wr && reg_addr == `WSC_ADDR_INT_STAT) begin
        int_stat_q <= (int_stat_q & ~reg_wdata[3:0]) | ev;
      end else begin
        int_stat_q <= int_stat_q | ev;
      end
      if (reg_wr && reg_addr == `WSC_ADDR_INT_MASK) begin
        int_mask_q <= reg_wdata[3:0];
      end
    end
  end
  assign irq = |(int_stat_q & int_mask_q);

  // Read data one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      if (reg_addr == `WSC_ADDR_CTRL) begin
        reg_rdata <= {24'h000000, ctrl_q};
      end else if (reg_addr == `WSC_ADDR_BACKOFF) begin
        reg_rdata <= {24'h000000, backoff_q};
      end else if (reg_addr == `WSC_ADDR_ANT_SEL) begin
        reg_rdata <= {28'h0000000, ant_sel_q};
      end else if (reg_addr == `WSC_ADDR_TBL_IDX) begin
        reg_rdata <= 32'(tbl_idx_q);
      end else if (reg_addr == `WSC_ADDR_TBL_DATA) begin
        reg_rdata <= {28'h0000000, tbl_q[tbl_idx_q]};
      end else if (reg_addr == `WSC_ADDR_MIPI_CMD) begin
        reg_rdata <= {16'h0000, mipi_word_q};
      end else if (reg_addr == `WSC_ADDR_INT_STAT) begin
        reg_rdata <= {28'h0000000, int_stat_q};
      end else if (reg_addr == `WSC_ADDR_INT_MASK) begin
        reg_rdata <= {28'h0000000, int_mask_q};
      end else if (reg_addr == `WSC_ADDR_STATUS) begin
        reg_rdata <= {29'h0, mif.busy, wake_busy, ~bo_s2_q};
      end else if (reg_addr == `WSC_ADDR_STRAPS) begin
        reg_rdata <= {28'h0000000, `WSC_STRAPS_VALUE};
      end else begin
        reg_rdata <= 32'h0000_0000;
      end
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // ==========================================
  // Wake pulse timer
  logic [31:0] wake_cnt_q;
  assign wake_busy = (wake_cnt_q != 32'h0000_0000);
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wake_cnt_q <= 32'h0000_0000;
    end else if (wake_busy) begin
      wake_cnt_q <= wake_cnt_q - 32'h0000_0001;
    end else if (wake_go) begin
      wake_cnt_q <= 32'(WAKE_CYCLES);
    end
  end
  assign wake_done_ev = (wake_cnt_q == 32'h0000_0001);
  // Output level fixed low; only the enable moves, so the pin is never driven high
  assign host_wake_request_n_o = 1'b0;
  assign host_wake_request_n_oe_n = ~wake_busy;

  // ==========================================
  // Back-off outputs
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      absorption_rate_limit <= 1'b0;
      backoff_amount <= 8'h00;
    end else begin
      // Pull-up keeps an open pin high, which lands here as no back-off
      absorption_rate_limit <= ~bo_s2_q;
      backoff_amount <= bo_s2_q ? 8'h00 : backoff_q;
    end
  end

  // ==========================================
  // Antenna controls: parallel mode drives table entry, serial mode parks pins low
  logic par_mode;
  wsc_ant_t ant_q;
  assign par_mode = !ctrl_q[`WSC_CTRL_MIPI_MODE];
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ant_q <= 4'h0;
    end else if (par_mode) begin
      ant_q <= tbl_q[ant_sel_q[IW-1:0]];
    end else begin
      ant_q <= 4'h0;
    end
  end
  assign antenna_switch_ctl_0 = ant_q[0];
  assign antenna_switch_ctl_1 = ant_q[1];
  assign antenna_switch_ctl_2 = ant_q[2];
  assign antenna_switch_ctl_3 = ant_q[3];

  assign mif.start = mipi_go_q && !par_mode;
  assign mif.word = mipi_word_q;

  wsc_mipi_ser u_ser (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .cmd(mif),
    .mipi_clk(mipi_clk),
    .mipi_data(mipi_data)
  );

  // ==========================================
  // Coexistence lines
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      coexist_line_1 <= 1'b0;
      coexist_line_2 <= 1'b0;
      coexist_line_3 <= 1'b0;
    end else begin
      coexist_line_1 <= tx_s2_q;
      coexist_line_2 <= fs_s2_q;
      coexist_line_3 <= tx_s2_q;
    end
  end

  // Straps are constant low
  assign config_strap = `WSC_STRAPS_VALUE;

  // Pin readback unused: open-drain state is known from the enable
  logic unused_wake_in;
  assign unused_wake_in = host_wake_request_n_i;
endmodule
`default_nettype wire

// File: tb/wsc_top_chk.sv
// Port-level assertions for the sideband top
`timescale 1ns/1ns
`default_nettype none
`include "wsc_regs.svh"
module wsc_top_chk #(
  parameter int WAKE_CYCLES = 100
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  // Pins
  input wire logic host_wake_request_n_o,
  input wire logic host_wake_request_n_oe_n,
  input wire logic tx_power_backoff_n,
  input wire logic cell_tx_active,
  input wire logic cell_frame_sync,
  input wire logic absorption_rate_limit,
  input wire wsc_pkg::wsc_byte_t backoff_amount,
  input wire logic coexist_line_1,
  input wire logic coexist_line_2,
  input wire logic coexist_line_3,
  input wire logic [3:0] config_strap
);
  import wsc_pkg::*;
  logic [31:0] low_q;
  logic [7:0] amt_q;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  // ====
  // Helpers
  // Length of the current wake pulse; zero while released
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) low_q <= '0;
    else if (host_wake_request_n_oe_n) low_q <= '0;
    else low_q <= low_q + 32'h1;
  end
  // Shadow of the reduction amount, so output can be tied to software
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) amt_q <= 8'h00;
    else if (reg_wr && reg_addr == `WSC_ADDR_BACKOFF) amt_q <= reg_wdata[7:0];
  end
  // ====
  // Assertions
  AST_WAKE_OD: assert property (host_wake_request_n_o == 1'b0)
    else $error("wake pin would be driven high");
  AST_WAKE_GO: assert property ((reg_wr && reg_addr == `WSC_ADDR_CTRL && reg_wdata[0]
    && host_wake_request_n_oe_n) |=> !host_wake_request_n_oe_n)
    else $error("wake request did not start a pulse");
  AST_WAKE_LEN: assert property ($rose(host_wake_request_n_oe_n) |-> low_q == WAKE_CYCLES)
    else $error("wake pulse length wrong");
  AST_WAKE_MAX: assert property (low_q <= WAKE_CYCLES)
    else $error("wake pulse extended");
  AST_BO_ON: assert property ((!tx_power_backoff_n)[*4] |-> absorption_rate_limit)
    else $error("back-off not applied");
  AST_BO_OFF: assert property (tx_power_backoff_n[*4] |->
    !absorption_rate_limit && backoff_amount == 8'h00)
    else $error("back-off applied while pin high");
  AST_BO_AMT: assert property ((absorption_rate_limit && $stable(amt_q)
    && amt_q == $past(amt_q, 2)) |-> backoff_amount == amt_q)
    else $error("reduction amount differs from setting");
  AST_COEX_TX: assert property (($stable(cell_tx_active))[*4] |->
    coexist_line_1 == cell_tx_active && coexist_line_3 == cell_tx_active)
    else $error("tx active lines wrong");
  AST_COEX_FS: assert property (($stable(cell_frame_sync))[*4] |->
    coexist_line_2 == cell_frame_sync)
    else $error("frame sync line wrong");
  AST_STRAPS: assert property (config_strap == 4'h0)
    else $error("straps not low");
  // Main scenarios reached
  cover property ($rose(host_wake_request_n_oe_n));
  cover property ($rose(absorption_rate_limit));
  cover property ($rose(coexist_line_2));
endmodule
bind wsc_top wsc_top_chk #(.WAKE_CYCLES(WAKE_CYCLES)) u_chk (
  .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .host_wake_request_n_o(host_wake_request_n_o),
  .host_wake_request_n_oe_n(host_wake_request_n_oe_n),
  .tx_power_backoff_n(tx_power_backoff_n), .cell_tx_active(cell_tx_active),
  .cell_frame_sync(cell_frame_sync), .absorption_rate_limit(absorption_rate_limit),
  .backoff_amount(backoff_amount), .coexist_line_1(coexist_line_1),
  .coexist_line_2(coexist_line_2), .coexist_line_3(coexist_line_3),
  .config_strap(config_strap)
);
`default_nettype wire

// File: tb/wsc_host_model.sv
// Host platform and antenna tuner as seen from the card pins
`timescale 1ns/1ns
`default_nettype none
module wsc_host_model (
  // Wake pin
  input wire logic wake_oe_n,
  input wire logic wake_o,
  output logic wake_wire,
  // Back-off request from the bench
  input wire logic backoff_req,
  output logic backoff_n,
  // Tuner serial pins
  input wire logic mipi_clk,
  input wire logic mipi_data,
  output logic [15:0] tuner_word,
  output logic [4:0] tuner_bits
);
  // Host pull-up wins whenever the card lets go
  assign wake_wire = wake_oe_n ? 1'b1 : wake_o;
  // Sensor level already debounced; a released pin is pulled up
  assign backoff_n = backoff_req ? 1'b0 : 1'b1;
  logic [15:0] word_q = 16'h0;
  logic [4:0] bits_q = 5'h0;
  // Tuner takes a bit on each rising serial clock, first bit lands on top
  always @(posedge mipi_clk) begin
    word_q <= {word_q[14:0], mipi_data};
    bits_q <= bits_q + 5'h1;
  end
  assign tuner_word = word_q;
  assign tuner_bits = bits_q;
endmodule
`default_nettype wire

// File: tb/wsc_top_test.sv
// Self-checking bench for the sideband top
`timescale 1ns/1ns
`default_nettype none
`include "wsc_regs.svh"
module wsc_top_test;
  import wsc_pkg::*;
  localparam int WAKE = 100;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic backoff_req = 1'b0;
  logic tx_act = 1'b0;
  logic fsync = 1'b0;
  logic [31:0] reg_rdata;
  logic irq, wake_wire, wake_o, wake_oe_n, backoff_n, arl, mclk, mdat;
  wsc_byte_t amount;
  logic [3:0] ant;
  logic [3:0] strap;
  logic [2:0] coex;
  logic [15:0] tword;
  logic [4:0] tbits;
  int fails = 0;
  int n_compared = 0;
  int n;
  // Short wake pulse keeps the run brief
  always #2 clk_sys = ~clk_sys;
  wsc_top #(.WAKE_CYCLES(WAKE)) dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .host_wake_request_n_i(wake_wire), .host_wake_request_n_o(wake_o),
    .host_wake_request_n_oe_n(wake_oe_n), .tx_power_backoff_n(backoff_n),
    .cell_tx_active(tx_act), .cell_frame_sync(fsync), .absorption_rate_limit(arl),
    .backoff_amount(amount), .antenna_switch_ctl_0(ant[0]), .antenna_switch_ctl_1(ant[1]),
    .antenna_switch_ctl_2(ant[2]), .antenna_switch_ctl_3(ant[3]), .mipi_clk(mclk),
    .mipi_data(mdat), .coexist_line_1(coex[0]), .coexist_line_2(coex[1]),
    .coexist_line_3(coex[2]), .config_strap(strap)
  );
  wsc_host_model host (
    .wake_oe_n(wake_oe_n), .wake_o(wake_o), .wake_wire(wake_wire),
    .backoff_req(backoff_req), .backoff_n(backoff_n), .mipi_clk(mclk),
    .mipi_data(mdat), .tuner_word(tword), .tuner_bits(tbits)
  );
  // ====
  // Bus and check tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rc(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    chk(reg_rdata, exp);
  endtask
  task automatic close_out();
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Watchdog well beyond the expected run of about 600 cycles
  initial begin
    #20000;
    fails++;
    close_out();
  end
  // ====
  // Tests
  initial begin
    repeat (16) @(posedge clk_sys);
    rst_b <= 1'b1;
    rc(`WSC_ADDR_STRAPS, 32'h0);
    chk({28'h0, strap}, 32'h0);
    rc(4'hA, 32'h0);
    // Back-off on and off, with its interrupt
    wr(`WSC_ADDR_BACKOFF, 32'h5A);
    wr(`WSC_ADDR_INT_MASK, 32'h1);
    backoff_req <= 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    chk({31'h0, arl}, 32'h1);
    chk({24'h0, amount}, 32'h5A);
    chk({31'h0, irq}, 32'h1);
    rc(`WSC_ADDR_STATUS, 32'h1);
    rc(`WSC_ADDR_BACKOFF, 32'h5A);
    wr(`WSC_ADDR_INT_STAT, 32'h1);
    @(negedge clk_sys);
    chk({31'h0, irq}, 32'h0);
    @(posedge clk_sys);
    backoff_req <= 1'b0;
    repeat (4) @(posedge clk_sys);
    #1;
    chk({23'h0, arl, amount}, 32'h0);
    rc(`WSC_ADDR_INT_STAT, 32'h2);
    wr(`WSC_ADDR_INT_STAT, 32'h2);
    // Wake pulse with a second request in mid-pulse
    wr(`WSC_ADDR_CTRL, 32'h1);
    fork
      begin
        repeat (30) @(posedge clk_sys);
        wr(`WSC_ADDR_CTRL, 32'h1);
        rc(`WSC_ADDR_STATUS, 32'h2);
        rc(`WSC_ADDR_CTRL, 32'h0);
      end
      begin
        n = 0;
        @(negedge clk_sys);
        while (wake_wire === 1'b0 && n < 400) begin
          n++;
          @(negedge clk_sys);
        end
      end
    join
    chk(n, WAKE);
    rc(`WSC_ADDR_INT_STAT, 32'h4);
    wr(`WSC_ADDR_INT_STAT, 32'h4);
    // Parallel antenna table
    for (int i = 0; i < 16; i++) begin
      wr(`WSC_ADDR_TBL_IDX, i);
      wr(`WSC_ADDR_TBL_DATA, 15 - i);
    end
    for (int i = 0; i < 16; i++) begin
      wr(`WSC_ADDR_ANT_SEL, i);
      repeat (2) @(posedge clk_sys);
      #1;
      chk({28'h0, ant}, 15 - i);
    end
    // Serial tuner word
    wr(`WSC_ADDR_CTRL, 32'h2);
    repeat (2) @(posedge clk_sys);
    #1;
    chk({28'h0, ant}, 32'h0);
    wr(`WSC_ADDR_MIPI_CMD, 32'hA5C3);
    n = 0;
    while (tbits < 5'h10 && n < 1000) begin
      @(posedge clk_sys);
      n++;
    end
    chk({16'h0, tword}, 32'hA5C3);
    rc(`WSC_ADDR_STATUS, 32'h4);
    repeat (40) @(posedge clk_sys);
    rc(`WSC_ADDR_INT_STAT, 32'h8);
    // Coexistence lines
    @(posedge clk_sys);
    tx_act <= 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    chk({29'h0, coex}, 32'h5);
    @(posedge clk_sys);
    tx_act <= 1'b0;
    fsync <= 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    chk({29'h0, coex}, 32'h2);
    close_out();
  end
endmodule
`default_nettype wire
